// File: i2cs_regs.svh
// register map, field positions and timing constants of the i2c slave
//
// Functional notes
// - transfer-complete low while moving, high plus interrupt
// - address-match flag set only on equal address
// - busy set on start, cleared on stop
// - direction bit one transmits, zero receives
// - after received byte drive ack bit
// - eighth bit after address stored as read/write
// - wake enable lets address match wake processor
// - sample master ack after transmitted byte
// - transmit while ack received, else release data
// - shift seven address bits msb first, compare
// - on match ack low, flag, interrupt
// - one interrupt for match, byte, timeout
// - hold clock until firmware data access
// - start is data fall while clock high
// - enable rising edge restores status flags
// - timeout resets status register, returns engine to idle, clears timeout enable
// - own address from upper seven bits
`ifndef I2CS_REGS_SVH
`define I2CS_REGS_SVH
// ***************
// register offsets
// ***************
`define I2CS_OFF_MODE  8'h00
`define I2CS_OFF_STAT  8'h04
`define I2CS_OFF_DATA  8'h08
`define I2CS_OFF_ADDR  8'h0C
`define I2CS_OFF_TMO   8'h10
`define I2CS_OFF_IE    8'h14
// ***************
// fields and reset values
// ***************
`define I2CS_MODE_POR  8'hE0
`define I2CS_STAT_POR  8'h81
`define I2CS_I2C_MODE  3'h6
`define I2CS_BITS      4'h8
// ***************
// timing
// ***************
`define I2CS_CLK_NS    8
`define I2CS_TO_UNIT_NS 976563
`endif

// File: i2cs_pkg.sv
// types shared by the i2c slave status logic
package i2cs_pkg;
  // bus engine states, one-hot
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_AACK = 9'h004,
    ST_HOLD = 9'h008,
    ST_TX   = 9'h010,
    ST_TACK = 9'h020,
    ST_RX   = 9'h040,
    ST_RACK = 9'h080,
    ST_WAIT = 9'h100
  } i2cs_st_t;
  // status/control register, bit 7 down to 0
  typedef struct packed {
    logic tcf;   // transfer_complete_flag
    logic amf;   // address_match_flag
    logic busy;  // bus_busy_flag
    logic dir;   // direction_select
    logic transmit_ack_bit;  // transmit_ack_bit
    logic rw;    // read_write_flag
    logic wake;  // match_wake_enable
    logic receive_ack_flag;  // receive_ack_flag
  } i2cs_stat_t;
endpackage

// File: i2cs_top.sv
// i2c slave address phase, status flags and apb register file
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "i2cs_regs.svh"
module i2cs_top #(
  parameter int TO_UNIT_CYC = `I2CS_TO_UNIT_NS / `I2CS_CLK_NS
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             scl_out,
  output logic             scl_oe,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             irq,
  output logic             wake
);
  import i2cs_pkg::*;

  // ***************
  // helpers
  // ***************
  // address decode, used for every register
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ***************
  // declarations
  // ***************
  logic [7:0]   mode_reg;     // serial_mode_control
  logic [7:0]   addr_reg;     // slave_address_register
  logic [7:0]   data_reg;     // shared_data_register
  logic         toen_reg;     // timeout enable
  logic         tof_reg;      // timeout_flag
  logic [5:0]   tsel_reg;     // timeout period select
  logic         ie_reg;       // interface_interrupt_enable
  i2cs_stat_t   stat_reg;     // serial_slave_status_control
  i2cs_st_t     st_reg;       // engine state
  logic [3:0]   cnt_reg;      // bit counter
  logic [7:0]   sh_reg;       // shift register
  logic [2:0]   scl_sy_reg;   // scl sync pair plus history
  logic [2:0]   sda_sy_reg;   // sda sync pair plus history
  logic         en_d_reg;     // enable history
  logic [31:0]  prdata_reg;
  logic         pready_reg;
  logic         pslverr_reg;
  logic         scl_oe_reg;
  logic         sda_oe_reg;
  logic         irq_reg;
  logic         wake_reg;
  logic         to_run_reg;   // timeout armed
  logic [31:0]  pre_reg;      // cycles inside one unit
  logic [5:0]   unit_reg;     // completed units
  // one-cycle events from the engine to the flags; ev_bit is not pulsed and holds the sampled bit
  logic ev_start, ev_stop, ev_match, ev_begin;
  logic ev_done, ev_ack, ev_bit, ev_rxb;

  // ***************
  // decode
  // ***************
  wire scl_s    = scl_sy_reg[1];
  wire scl_d    = scl_sy_reg[2];
  wire sda_s    = sda_sy_reg[1];
  wire sda_d    = sda_sy_reg[2];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;
  wire enable   = mode_reg[1];
  wire active   = enable & (mode_reg[7:5] == `I2CS_I2C_MODE);
  wire en_rise  = enable & ~en_d_reg;
  wire acc_done = psel & penable & pready_reg;
  wire wr_hit   = acc_done & pwrite;
  wire rd_hit   = acc_done & ~pwrite;
  wire h_mode   = hit(paddr, `I2CS_OFF_MODE);
  wire h_stat   = hit(paddr, `I2CS_OFF_STAT);
  wire h_data   = hit(paddr, `I2CS_OFF_DATA);
  wire h_addr   = hit(paddr, `I2CS_OFF_ADDR);
  wire h_tmo    = hit(paddr, `I2CS_OFF_TMO);
  wire h_ie     = hit(paddr, `I2CS_OFF_IE);
  wire mapped   = h_mode | h_stat | h_data | h_addr | h_tmo | h_ie;
  wire data_wr  = wr_hit & h_data;
  wire data_rd  = rd_hit & h_data;
  wire pre_end  = (pre_reg == TO_UNIT_CYC - 1);
  // timeout fires after (select+1) units without an scl fall
  wire to_fire  = to_run_reg & toen_reg & pre_end
                  & (unit_reg == tsel_reg);
  wire addr_eq  = (sh_reg[7:1] == addr_reg[7:1]);
  wire [7:0] rd_byte =
      h_mode ? mode_reg :
      h_stat ? stat_reg :
      h_data ? data_reg :
      h_addr ? addr_reg :
      h_tmo  ? {toen_reg, tof_reg, tsel_reg} :
      h_ie   ? {7'h00, ie_reg} : 8'h00;

  // ***************
  // pin synchronisers
  // ***************
  // bit 0 is only read by bit 1; edges use bits 1 and 2
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_sy_reg <= 3'h7;
      sda_sy_reg <= 3'h7;
    end else begin
      scl_sy_reg <= {scl_sy_reg[1:0], scl_in};
      sda_sy_reg <= {sda_sy_reg[1:0], sda_in};
    end
  end

  // ***************
  // apb slave
  // ***************
  // one wait state: answer registered on the second access cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= psel & penable & ~pready_reg;
      pslverr_reg <= psel & penable & ~pready_reg & ~mapped;
      if (psel & penable & ~pready_reg)
        prdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  // plain configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg <= `I2CS_MODE_POR;
      addr_reg <= 8'h00;
      ie_reg   <= 1'b0;
      tsel_reg <= 6'h00;
      en_d_reg <= 1'b0;
    end else begin
      en_d_reg <= enable;
      // bit 4 is unimplemented and reads as zero
      if (wr_hit & h_mode) mode_reg <= pwdata[7:0] & 8'hEF;
      if (wr_hit & h_addr) addr_reg <= pwdata[7:0];
      if (wr_hit & h_ie)   ie_reg   <= pwdata[0];
      if (wr_hit & h_tmo)  tsel_reg <= pwdata[5:0];
    end
  end

  // data register: firmware writes, received bytes land here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) data_reg <= 8'h00;
    else if (ev_rxb) data_reg <= sh_reg;
    else if (data_wr) data_reg <= pwdata[7:0];
  end

  // ***************
  // timeout
  // ***************
  // armed by start plus match, restarted by each scl fall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      to_run_reg <= 1'b0;
      pre_reg    <= 32'h0000_0000;
      unit_reg   <= 6'h00;
    end else begin
      if (ev_match) to_run_reg <= 1'b1;
      else if (stop_det | to_fire | ~active) to_run_reg <= 1'b0;
      if (~to_run_reg | scl_fall | pre_end) pre_reg <= 32'h0000_0000;
      else pre_reg <= pre_reg + 32'h0000_0001;
      if (~to_run_reg | scl_fall) unit_reg <= 6'h00;
      else if (pre_end) unit_reg <= unit_reg + 6'h01;
    end
  end

  // enable clears on a timeout; flag set beats a software clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      toen_reg <= 1'b0;
      tof_reg  <= 1'b0;
    end else begin
      if (wr_hit & h_tmo) begin
        toen_reg <= pwdata[7];
        tof_reg  <= pwdata[6];
      end
      if (to_fire) begin
        toen_reg <= 1'b0;
        tof_reg  <= 1'b1;
      end
    end
  end

  // ***************
  // bus engine
  // ***************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg     <= ST_IDLE;
      cnt_reg    <= 4'h0;
      sh_reg     <= 8'h00;
      sda_oe_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      ev_start <= 1'b0; ev_stop <= 1'b0; ev_match <= 1'b0;
      ev_begin <= 1'b0; ev_done <= 1'b0; ev_ack   <= 1'b0;
      ev_bit   <= 1'b0; ev_rxb  <= 1'b0;
    end else begin
      ev_start <= 1'b0; ev_stop <= 1'b0; ev_match <= 1'b0;
      ev_begin <= 1'b0; ev_done <= 1'b0; ev_ack   <= 1'b0;
      ev_rxb   <= 1'b0;
      if (~active | to_fire) begin
        // disabled or timed out: let go of both lines
        st_reg     <= ST_IDLE;
        sda_oe_reg <= 1'b0;
        scl_oe_reg <= 1'b0;
      end else if (start_det) begin
        st_reg     <= ST_ADDR;
        cnt_reg    <= 4'h0;
        sda_oe_reg <= 1'b0;
        scl_oe_reg <= 1'b0;
        ev_start   <= 1'b1;
        ev_begin   <= 1'b1;
      end else if (stop_det) begin
        st_reg     <= ST_IDLE;
        sda_oe_reg <= 1'b0;
        scl_oe_reg <= 1'b0;
        ev_stop    <= 1'b1;
      end else begin
        case (st_reg)
          ST_ADDR: begin
            // seven address bits msb first, then read/write
            if (scl_rise) begin
              sh_reg  <= {sh_reg[6:0], sda_s};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == `I2CS_BITS) begin
              if (addr_eq) begin
                sda_oe_reg <= 1'b1;
                ev_match   <= 1'b1;
                ev_bit     <= sh_reg[0];
                st_reg     <= ST_AACK;
              end else begin
                st_reg <= ST_WAIT;
              end
            end
          end
          ST_AACK: begin
            // end of 9th clock: release data, stretch clock
            if (scl_fall) begin
              sda_oe_reg <= 1'b0;
              scl_oe_reg <= 1'b1;
              st_reg     <= ST_HOLD;
            end
          end
          ST_HOLD: begin
            // firmware access to the data register frees scl
            if (stat_reg.dir & data_wr) begin
              scl_oe_reg <= 1'b0;
              sh_reg     <= pwdata[7:0];
              sda_oe_reg <= ~pwdata[7];
              cnt_reg    <= 4'h0;
              ev_begin   <= 1'b1;
              st_reg     <= ST_TX;
            end else if (~stat_reg.dir & data_rd) begin
              scl_oe_reg <= 1'b0;
              cnt_reg    <= 4'h0;
              ev_begin   <= 1'b1;
              st_reg     <= ST_RX;
            end
          end
          ST_TX: begin
            // next bit goes out on each falling scl
            if (scl_rise) begin
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall) begin
              if (cnt_reg == `I2CS_BITS) begin
                sda_oe_reg <= 1'b0;
                st_reg     <= ST_TACK;
              end else begin
                sh_reg     <= {sh_reg[6:0], 1'b0};
                sda_oe_reg <= ~sh_reg[6];
              end
            end
          end
          ST_TACK: begin
            if (scl_rise) begin
              ev_ack  <= 1'b1;
              ev_bit  <= sda_s;
              ev_done <= 1'b1;
            end else if (scl_fall) begin
              // acked: hold for next byte; else leave sda free
              if (~stat_reg.receive_ack_flag) begin
                scl_oe_reg <= 1'b1;
                st_reg     <= ST_HOLD;
              end else begin
                st_reg <= ST_WAIT;
              end
            end
          end
          ST_RX: begin
            if (scl_rise) begin
              sh_reg  <= {sh_reg[6:0], sda_s};
              cnt_reg <= cnt_reg + 4'h1;
              if (cnt_reg == `I2CS_BITS - 4'h1) begin
                ev_rxb  <= 1'b1;
                ev_done <= 1'b1;
              end
            end else if (scl_fall && cnt_reg == `I2CS_BITS) begin
              sda_oe_reg <= ~stat_reg.transmit_ack_bit;
              st_reg     <= ST_RACK;
            end
          end
          ST_RACK: begin
            if (scl_fall) begin
              sda_oe_reg <= 1'b0;
              scl_oe_reg <= 1'b1;
              st_reg     <= ST_HOLD;
            end
          end
          ST_IDLE, ST_WAIT: begin
            // not addressed or done: wait for start or stop
            sda_oe_reg <= 1'b0;
          end
          default: begin
            st_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ***************
  // status flags
  // ***************
  // hardware events follow the software write, so a set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_reg <= `I2CS_STAT_POR;
    end else if (to_fire) begin
      stat_reg <= `I2CS_STAT_POR;
    end else if (en_rise) begin
      // control bits kept, flags back to defaults
      stat_reg.tcf  <= 1'b1;
      stat_reg.amf  <= 1'b0;
      stat_reg.busy <= 1'b0;
      stat_reg.rw   <= 1'b0;
      stat_reg.receive_ack_flag <= 1'b1;
    end else begin
      if (wr_hit & h_stat) begin
        stat_reg.dir  <= pwdata[4];
        stat_reg.transmit_ack_bit <= pwdata[3];
        stat_reg.wake <= pwdata[1];
      end
      if (ev_start) begin
        stat_reg.busy <= 1'b1;
        stat_reg.amf  <= 1'b0;
      end
      if (ev_stop) stat_reg.busy <= 1'b0;
      if (ev_begin) stat_reg.tcf <= 1'b0;
      if (ev_done) stat_reg.tcf <= 1'b1;
      if (ev_match) begin
        stat_reg.amf <= 1'b1;
        stat_reg.rw  <= ev_bit;
      end
      if (ev_ack) stat_reg.receive_ack_flag <= ev_bit;
    end
  end

  // ***************
  // interrupt and wake pulses
  // ***************
  // one shared request for match, byte done and timeout
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_reg  <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      irq_reg  <= ie_reg & (ev_match | ev_done | to_fire);
      wake_reg <= stat_reg.wake & ev_match;
    end
  end

  // ***************
  // outputs
  // ***************
  // open-drain: lines only ever pulled low
  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = scl_oe_reg;
  assign sda_oe  = sda_oe_reg;
  assign irq     = irq_reg;
  assign wake    = wake_reg;
endmodule

// File: i2cs_chk.sv
// port checker for the i2c slave status block
`timescale 1ns/100ps
`include "i2cs_regs.svh"
module i2cs_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] paddr,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       scl_in,
  input wire logic       scl_out,
  input wire logic       scl_oe,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       irq,
  input wire logic       wake
);
  // *****
  // helper logic
  // *****
  logic [3:0] acc_reg;  // cycles since a data register access, saturating
  wire        acc_hit;  // data register access completes this edge
  assign acc_hit = psel & penable & pready & (paddr == `I2CS_OFF_DATA);
  // age counter, so a clock release can be tied to firmware
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_reg <= 4'hF;
    end else if (acc_hit) begin
      acc_reg <= 4'h0;
    end else if (acc_reg != 4'hF) begin
      acc_reg <= acc_reg + 4'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // *****
  // assertions
  // *****
  a_irq_pulse: assert property (irq |=> !irq)
    else $error("irq longer than one cycle");
  a_wake_pulse: assert property (wake |=> !wake)
    else $error("wake longer than one cycle");
  a_wake_ack: assert property (wake |-> sda_oe)
    else $error("wake without address acknowledge");
  a_ack_hold: assert property ($rose(sda_oe) |=> sda_oe [*3])
    else $error("data drive shorter than a bit");
  a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data moved while clock high");
  a_stretch_low: assert property ($rose(scl_oe) |-> !$past(scl_in))
    else $error("stretch began with clock high");
  // a timeout also frees scl; its interrupt pulse marks that edge
  a_stretch_rel: assert property ($fell(scl_oe) |-> acc_reg < 4'h4 || irq)
    else $error("clock released without data access");
  a_open_drain: assert property (!scl_out && !sda_out)
    else $error("open drain value not low");
  // main scenarios reached
  c_wake: cover property (wake);
  c_release: cover property ($fell(scl_oe));
  c_two_irq: cover property (irq ##[2:400] irq);
endmodule
bind i2cs_top i2cs_chk u_chk (.clk(clk), .rst(rst), .paddr(paddr),
  .psel(psel), .penable(penable), .pready(pready), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
  .sda_oe(sda_oe), .irq(irq), .wake(wake));

// File: i2cs_mst.sv
// behavioural bus master on open-drain clock and data lines
`timescale 1ns/100ps
module i2cs_mst (
  input  wire logic scl,     // clock wire level
  input  wire logic sda,     // data wire level
  output logic      scl_oe,  // high pulls clock low
  output logic      sda_oe   // high pulls data low
);
  // released lines rest on their pull-ups
  initial begin
    scl_oe = 1'h0;
    sda_oe = 1'h0;
  end
  // start: data falls while clock stays high
  task automatic start();
    #3 sda_oe = 1'h1;
    #20 scl_oe = 1'h1;
  endtask
  // one bit; waits out stretching, so a hung slave needs the bench limit
  task automatic bit_io(input logic b, output logic r);
    #21 sda_oe = !b;
    #24 scl_oe = 1'h0;
    wait (scl === 1'h1);
    #3;
    #16 r = sda;
    #16 scl_oe = 1'h1;
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [8:0] o, output logic [8:0] i);
    for (int k = 8; k >= 0; k--) begin
      bit_io(o[k], i[k]);
    end
  endtask
  // stop: data rises while clock high; clock then stands still
  task automatic stop();
    #21 sda_oe = 1'h1;
    #24 scl_oe = 1'h0;
    wait (scl === 1'h1);
    #19 sda_oe = 1'h0;
    #16;
  endtask
endmodule

// File: tb.sv
// self-checking bench for the i2c slave status block
`timescale 1ns/100ps
`include "i2cs_regs.svh"
module tb;
  import i2cs_pkg::*;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, irq, wake;
  logic        d_scl_oe, d_sda_oe, d_scl_o, d_sda_o;  // design pin drive
  logic        m_scl_oe, m_sda_oe;                    // master pin drive
  wire         scl = !(d_scl_oe | m_scl_oe);          // pulled-up wires
  wire         sda = !(d_sda_oe | m_sda_oe);
  logic [64:0] exp_q[$], note;  // notes: mask, error, data
  logic [6:0]  own;             // own slave address
  logic [7:0]  d0, d1;          // random payloads
  logic [8:0]  got;             // bits seen by the master
  int n_fail = 0, check_count = 0, n_irq = 0, n_wake = 0, cyc = 0;
  always #4 clk = !clk;
  i2cs_top #(.TO_UNIT_CYC(20)) DUT (.clk(clk), .rst(rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
    .sda_in(sda), .scl_out(d_scl_o), .scl_oe(d_scl_oe), .sda_out(d_sda_o),
    .sda_oe(d_sda_oe), .irq(irq), .wake(wake));
  i2cs_mst mdl (.scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
  // compare and report at once
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer, note queued before the request
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     logic [31:0] m, logic e);
    @(posedge clk);
    exp_q.push_back({m, e, d});
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  // counts, verdict and end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // watcher: each completed access takes the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'h1) begin
      note = exp_q.pop_front();
      chk("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
      if (!pwrite) chk("prdata", note[31:0] & note[64:33],
                       prdata & note[64:33]);
    end
  end
  // event counters and run limit, a hang counts as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (irq === 1'h1) n_irq++;
    if (wake === 1'h1) n_wake++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  // *****
  // main sequence
  // *****
  initial begin
    void'($urandom(32'h2FAFFD5D));
    {own, d0, d1} = 23'($urandom());
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    apb(0, `I2CS_OFF_STAT, 32'h81, 32'hFF, 0);
    apb(0, `I2CS_OFF_MODE, 32'hE0, 32'hFF, 0);
    apb(0, 8'h18, 32'h0, 32'hFFFFFFFF, 1);
    apb(1, 8'h18, 32'hFF, 32'h0, 1);
    apb(1, `I2CS_OFF_MODE, 32'hC2, 32'h0, 0);
    apb(0, `I2CS_OFF_STAT, 32'h81, 32'hFF, 0);
    apb(1, `I2CS_OFF_ADDR, {24'h0, own, 1'h0}, 32'h0, 0);
    apb(1, `I2CS_OFF_IE, 32'h1, 32'h0, 0);
    apb(1, `I2CS_OFF_STAT, 32'hFF, 32'h0, 0);
    apb(0, `I2CS_OFF_STAT, 32'h9B, 32'hFF, 0);
    $display("test registers done");
    mdl.start();
    mdl.xfer({own ^ 7'h01, 1'h0, 1'h1}, got);
    chk("foreign ack", 32'h1, {31'h0, got[0]});
    mdl.stop();
    chk("irq count", 32'h0, n_irq);
    $display("test foreign address done");
    apb(1, `I2CS_OFF_STAT, 32'h02, 32'h0, 0);
    mdl.start();
    mdl.xfer({own, 1'h0, 1'h1}, got);
    chk("address ack", 32'h0, {31'h0, got[0]});
    apb(0, `I2CS_OFF_STAT, 32'h62, 32'h66, 0);
    chk("wake count", 32'h1, n_wake);
    apb(0, `I2CS_OFF_DATA, 32'h0, 32'h0, 0);
    mdl.xfer({d0, 1'h1}, got);
    chk("byte ack", 32'h0, {31'h0, got[0]});
    apb(1, `I2CS_OFF_STAT, 32'h08, 32'h0, 0);
    apb(0, `I2CS_OFF_STAT, 32'h80, 32'h80, 0);
    apb(0, `I2CS_OFF_DATA, {24'h0, d0}, 32'hFF, 0);
    mdl.xfer({d1, 1'h1}, got);
    chk("byte nack", 32'h1, {31'h0, got[0]});
    apb(0, `I2CS_OFF_DATA, {24'h0, d1}, 32'hFF, 0);
    mdl.stop();
    apb(0, `I2CS_OFF_STAT, 32'h0, 32'h20, 0);
    chk("irq count", 32'h3, n_irq);
    $display("test master write done");
    apb(1, `I2CS_OFF_STAT, 32'h00, 32'h0, 0);
    mdl.start();
    mdl.xfer({own, 1'h1, 1'h1}, got);
    chk("address ack", 32'h0, {31'h0, got[0]});
    apb(0, `I2CS_OFF_STAT, 32'h64, 32'h64, 0);
    apb(1, `I2CS_OFF_STAT, 32'h10, 32'h0, 0);
    apb(1, `I2CS_OFF_DATA, {24'h0, d0}, 32'h0, 0);
    mdl.xfer(9'h1FE, got);
    chk("sent byte", {24'h0, d0}, {24'h0, got[8:1]});
    apb(0, `I2CS_OFF_STAT, 32'h0, 32'h01, 0);
    apb(1, `I2CS_OFF_DATA, {24'h0, d1}, 32'h0, 0);
    mdl.xfer(9'h1FF, got);
    chk("sent byte", {24'h0, d1}, {24'h0, got[8:1]});
    apb(0, `I2CS_OFF_STAT, 32'h1, 32'h01, 0);
    chk("sda_oe", 32'h0, {31'h0, d_sda_oe});
    mdl.stop();
    $display("test master read done");
    apb(1, `I2CS_OFF_MODE, 32'hC0, 32'h0, 0);
    apb(1, `I2CS_OFF_MODE, 32'hC2, 32'h0, 0);
    apb(0, `I2CS_OFF_STAT, 32'h91, 32'hFF, 0);
    $display("test enable restart done");
    apb(1, `I2CS_OFF_TMO, 32'h80, 32'h0, 0);
    mdl.start();
    mdl.xfer({own, 1'h0, 1'h1}, got);
    repeat (40) @(posedge clk);
    apb(0, `I2CS_OFF_TMO, 32'h40, 32'hFF, 0);
    apb(0, `I2CS_OFF_STAT, 32'h81, 32'hFF, 0);
    mdl.stop();
    chk("irq count", 32'h8, n_irq);
    $display("test timeout done");
    repeat (2) @(posedge clk);
    print_verdict();
  end
endmodule
